// ===== common/cbc_defs.svh
// constants for the core build configuration block
`ifndef CBC_DEFS_SVH
`define CBC_DEFS_SVH
`define CBC_ADDR_PU_TYPE 32'hE000ED90
`define CBC_ADDR_VTB 32'hE000ED08
`define CBC_ADDR_CFG_ID 32'hE000EFF0
`define CBC_ADDR_PRIO_BASE 32'hE000E400
`define CBC_ADDR_STATUS 32'hE000EFF4
`define CBC_ADDR_BOOT 32'hE000EFF8
`define CBC_ADDR_GPR_BASE 32'hE000EE00
`define CBC_PRIO_WORDS 60
`define CBC_GPR_COUNT 16
`define CBC_REGION_COUNT_FIELD_LSB 8
`define CBC_TBL_LSB 7
`define CBC_MAX_IRQ 240
`define CBC_MIN_PRIO_BITS 3
`define CBC_MAX_PRIO_BITS 8
`endif

// ===== common/cbc_pkg.sv
// types for the core build configuration block
package cbc_pkg;
  typedef enum logic [1:0] {
    CBC_FPU_NONE,
    CBC_FPU_SINGLE,
    CBC_FPU_DOUBLE
  } cbc_fpu_t;
  typedef enum logic [1:0] {
    CBC_BOOT_RESET,
    CBC_BOOT_SP,
    CBC_BOOT_PC,
    CBC_BOOT_DONE
  } cbc_boot_unused_t;
endpackage

// ===== design/cbc_prio_field.sv
// one eight bit priority field with unimplemented low bits forced to zero
module cbc_prio_field #(
  parameter int PRIO_BITS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  localparam logic [7:0] KEEP_MASK = 8'(8'hFF << (8 - PRIO_BITS));
  // low bits discard writes and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 8'h00;
    end else if (we_i) begin
      q_o <= wdata_i & KEEP_MASK;
    end
  end
endmodule // cbc_prio_field

// ===== design/cbc_core_config.sv
// build options, straps and configuration registers of a processor core
//
// Local design decision: the Wishbone register port.
module cbc_core_config #(
  parameter int NUM_IRQ = 240,
  parameter int PRIO_BITS = 8,
  parameter bit PU_PRESENT = 1'b1,
  parameter int PU_REGIONS = 8,
  parameter cbc_pkg::cbc_fpu_t FPU_CFG = cbc_pkg::CBC_FPU_DOUBLE,
  parameter bit GPR_RESET = 1'b1,
  parameter logic [31:0] CFG_ID = 32'h0000C0DE // arbitrary identity value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic endianness_strap_i,
  input wire logic [24:0] vector_base_strap_i,
  output logic big_endian_o,
  output logic [31:0] boot_addr_o,
  output logic boot_fetch_o,
  output logic boot_sp_phase_o,
  output logic boot_done_o
);
  `include "cbc_defs.svh"

  localparam int PRIO_WORDS = (NUM_IRQ + 3) / 4;

  // refuse builds the logic cannot serve
  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > `CBC_MAX_IRQ) begin
      $error("interrupt count out of range");
    end
    if (PRIO_BITS < `CBC_MIN_PRIO_BITS || PRIO_BITS > `CBC_MAX_PRIO_BITS) begin
      $error("priority bit count out of range");
    end
    if (PU_PRESENT && PU_REGIONS != 8 && PU_REGIONS != 16) begin
      $error("protection unit region count must be 8 or 16");
    end
    // only the three float builds have an encoding in the build word
    if (FPU_CFG != cbc_pkg::CBC_FPU_NONE && FPU_CFG != cbc_pkg::CBC_FPU_SINGLE &&
        FPU_CFG != cbc_pkg::CBC_FPU_DOUBLE) begin
      $error("float unit option not recognised");
    end
    // the priority window must not run past its fixed address range
    if (PRIO_WORDS > `CBC_PRIO_WORDS) begin
      $error("priority window too large");
    end
  end

  typedef enum {
    CBC_BT_SP,
    CBC_BT_PC,
    CBC_BT_DONE
  } cbc_boot_state_t;

  logic big_endian_r;
  logic [24:0] tbl_r;
  cbc_boot_state_t boot_r;
  logic [31:0] gpr_r [`CBC_GPR_COUNT];
  logic [7:0] prio_q [PRIO_WORDS*4];
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic req;
  logic wr_ok;
  logic [31:0] pu_type;
  logic [31:0] cfg_word;
  logic [31:0] status_word;
  logic [31:0] adr_word;
  logic vtb_hit;
  logic cfg_gpr_reset;
  logic [1:0] cfg_fpu;
  logic cfg_pu;
  logic [3:0] cfg_prio_bits;
  logic [7:0] cfg_irq_count;

  assign adr_word = {wb_adr_i[31:2], 2'b00};

  // table base register selected by the current request
  assign vtb_hit = (adr_word == `CBC_ADDR_VTB);
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr_ok = req & wb_we_i & ~err_nxt;

  // type register reads zero when the unit is left out
  assign pu_type = PU_PRESENT ? (32'(PU_REGIONS) << `CBC_REGION_COUNT_FIELD_LSB) : 32'h0000_0000;

  // build options as fixed fields, never changed while running
  assign cfg_gpr_reset = 1'(GPR_RESET);
  assign cfg_fpu = 2'(FPU_CFG);
  assign cfg_pu = 1'(PU_PRESENT);
  assign cfg_prio_bits = 4'(PRIO_BITS);
  assign cfg_irq_count = 8'(NUM_IRQ);

  // read only configuration word: irq count, prio bits, pu, float, gpr reset
  assign cfg_word = {10'h000, cfg_gpr_reset, cfg_fpu, cfg_pu, cfg_prio_bits,
                     6'h00, cfg_irq_count};

  // status word: byte order in bit 0, boot finished in bit 3
  assign status_word = {28'h0000000, boot_done_o, 1'b0, 1'b0, big_endian_r};

  // straps are captured only while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      big_endian_r <= endianness_strap_i;
    end
  end

  // table base: strap value during reset, software writes afterwards
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_r <= vector_base_strap_i;
    end else if (wr_ok && vtb_hit) begin
      if (wb_sel_i[0]) tbl_r[0] <= wb_dat_i[7];
      if (wb_sel_i[1]) tbl_r[8:1] <= wb_dat_i[15:8];
      if (wb_sel_i[2]) tbl_r[16:9] <= wb_dat_i[23:16];
      if (wb_sel_i[3]) tbl_r[24:17] <= wb_dat_i[31:24];
    end
  end

  // boot sequence: stack pointer word then program counter word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_r <= CBC_BT_SP;
    end else begin
      case (boot_r)
        CBC_BT_SP: boot_r <= CBC_BT_PC;
        CBC_BT_PC: boot_r <= CBC_BT_DONE;
        CBC_BT_DONE: boot_r <= CBC_BT_DONE;
        default: boot_r <= CBC_BT_DONE;
      endcase
    end
  end

  // fetch strobe, high for the two boot word cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_fetch_o <= 1'b0;
    end else begin
      boot_fetch_o <= (boot_r != CBC_BT_DONE);
    end
  end

  // first fetch carries the stack pointer word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_sp_phase_o <= 1'b0;
    end else begin
      boot_sp_phase_o <= (boot_r == CBC_BT_SP);
    end
  end

  // fetch address: table base, then the next word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_addr_o <= 32'h0000_0000;
    end else begin
      boot_addr_o <= {tbl_r, 7'h00} + ((boot_r == CBC_BT_PC) ? 32'h0000_0004 : 32'h0000_0000);
    end
  end

  assign boot_done_o = (boot_r == CBC_BT_DONE);
  assign big_endian_o = big_endian_r;

  // register bank, reset only when the build asks for it
  for (genvar g = 0; g < `CBC_GPR_COUNT; g++) begin : g_gpr
    always_ff @(posedge clk_i) begin
      if (rst_i && GPR_RESET) begin
        gpr_r[g] <= 32'h0000_0000;
      end else if (!rst_i && wr_ok && adr_word == `CBC_ADDR_GPR_BASE + 32'(g * 4)) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) gpr_r[g][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // priority fields, one byte each, four per word
  for (genvar p = 0; p < PRIO_WORDS * 4; p++) begin : g_prio
    logic hit;
    assign hit = wr_ok && wb_sel_i[p % 4] && (p < NUM_IRQ) &&
                 adr_word == `CBC_ADDR_PRIO_BASE + 32'((p / 4) * 4);
    cbc_prio_field #(
      .PRIO_BITS(PRIO_BITS)
    ) u_field (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(hit),
      .wdata_i(wb_dat_i[(p % 4) * 8 +: 8]),
      .q_o(prio_q[p])
    );
  end

  // read decode, unmapped addresses answer with err
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (adr_word == `CBC_ADDR_PU_TYPE) begin
      rdata_nxt = pu_type;
      err_nxt = wb_we_i;
    end else if (vtb_hit) begin
      rdata_nxt = {tbl_r, 7'h00};
    end else if (adr_word == `CBC_ADDR_CFG_ID) begin
      rdata_nxt = CFG_ID;
      err_nxt = wb_we_i;
    end else if (adr_word == `CBC_ADDR_STATUS) begin
      rdata_nxt = status_word;
      err_nxt = wb_we_i;
    end else if (adr_word == `CBC_ADDR_BOOT) begin
      rdata_nxt = cfg_word;
      err_nxt = wb_we_i;
    end else if (adr_word >= `CBC_ADDR_PRIO_BASE &&
                 adr_word < `CBC_ADDR_PRIO_BASE + 32'(PRIO_WORDS * 4)) begin
      for (int i = 0; i < PRIO_WORDS; i++) begin
        if (adr_word == `CBC_ADDR_PRIO_BASE + 32'(i * 4)) begin
          rdata_nxt = {prio_q[i*4+3], prio_q[i*4+2], prio_q[i*4+1], prio_q[i*4]};
        end
      end
    end else if (adr_word >= `CBC_ADDR_GPR_BASE &&
                 adr_word < `CBC_ADDR_GPR_BASE + 32'(`CBC_GPR_COUNT * 4)) begin
      for (int i = 0; i < `CBC_GPR_COUNT; i++) begin
        if (adr_word == `CBC_ADDR_GPR_BASE + 32'(i * 4)) begin
          rdata_nxt = gpr_r[i];
        end
      end
    end else begin
      err_nxt = 1'b1;
    end
  end

  // single cycle acknowledge, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~err_nxt;
    end
  end

  // error answer for refused writes and unmapped addresses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req & err_nxt;
    end
  end

  // read data stands with ack only, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= (req & ~wb_we_i & ~err_nxt) ? rdata_nxt : 32'h0000_0000;
    end
  end
endmodule // cbc_core_config

// ===== test/cbc_core_config_chk.sv
// assertion checker for the core build configuration block
`include "cbc_defs.svh"
module cbc_core_config_chk #(
  parameter int PRIO_BITS = 8,
  parameter bit PU_PRESENT = 1'b1,
  parameter int PU_REGIONS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic endianness_strap_i,
  input wire logic [24:0] vector_base_strap_i,
  input wire logic big_endian_o,
  input wire logic [31:0] boot_addr_o,
  input wire logic boot_fetch_o,
  input wire logic boot_sp_phase_o,
  input wire logic boot_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MSK = 8'((1 << (8 - PRIO_BITS)) - 1);
  logic take;
  logic prio;
  // request accepted at this edge, and whether it hits the priority fields
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign prio = wb_adr_i >= `CBC_ADDR_PRIO_BASE && wb_adr_i < `CBC_ADDR_PRIO_BASE + 32'hF0;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_be_cap; $fell(rst_i) |-> big_endian_o == $past(endianness_strap_i); endproperty
  a_be_cap: assert property (p_be_cap) else $error("byte order not from strap");
  property p_be_hold; 1'b1 |=> $stable(big_endian_o); endproperty
  a_be_hold: assert property (p_be_hold) else $error("byte order moved after reset");
  property p_boot_sp; $fell(rst_i) |=> boot_fetch_o && boot_sp_phase_o
    && boot_addr_o == {$past(vector_base_strap_i, 2), 7'h00}; endproperty
  a_boot_sp: assert property (p_boot_sp) else $error("stack word fetch wrong");
  property p_boot_pc; boot_fetch_o && boot_sp_phase_o |=> boot_fetch_o && !boot_sp_phase_o
    && boot_addr_o == $past(boot_addr_o) + 32'h4 ##1 !boot_fetch_o; endproperty
  a_boot_pc: assert property (p_boot_pc) else $error("program word fetch wrong");
  property p_done; $fell(rst_i) |-> ##2 boot_done_o [*3]; endproperty
  a_done: assert property (p_done) else $error("boot not done");
  property p_type; take && !wb_we_i && wb_adr_i == `CBC_ADDR_PU_TYPE |=> wb_ack_o
    && wb_dat_o[15:8] == (PU_PRESENT ? 8'(PU_REGIONS) : 8'h00); endproperty
  a_type: assert property (p_type) else $error("region count wrong");
  property p_ro; take && wb_we_i && wb_adr_i == `CBC_ADDR_PU_TYPE |=> wb_err_o && !wb_ack_o; endproperty
  a_ro: assert property (p_ro) else $error("type register write not refused");
  property p_prio; take && !wb_we_i && prio |=> wb_ack_o && (wb_dat_o & {4{MSK}}) == 32'h0; endproperty
  a_prio: assert property (p_prio) else $error("low priority bits not zero");
endmodule // cbc_core_config_chk

// ===== test/cbc_strap_model.sv
// strap source standing in for the system around the core
module cbc_strap_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic be_i,
  input wire logic [24:0] base_i,
  output logic endianness_strap_o,
  output logic [24:0] vector_base_strap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // straps hold the chosen level in reset and churn every cycle afterwards
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endianness_strap_o <= be_i;
      vector_base_strap_o <= base_i;
    end else begin
      endianness_strap_o <= ~endianness_strap_o;
      vector_base_strap_o <= ~vector_base_strap_o;
    end
  end
endmodule // cbc_strap_model

// ===== test/cbc_core_config_test.sv
// self-checking bench for the core build configuration block
`include "cbc_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t mismatch", $time); end end
module cbc_core_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, be = 1'b0, e;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, boot_addr_o, q;
  logic [24:0] base = 25'h0, vector_base_strap_i;
  logic wb_ack_o, wb_err_o, endianness_strap_i, big_endian_o, boot_fetch_o, boot_sp_phase_o, boot_done_o;
  int errors = 0, checks_done = 0;
  always #50 clk_i = ~clk_i;
  cbc_strap_model model (.clk_i(clk_i), .rst_i(rst_i), .be_i(be), .base_i(base),
    .endianness_strap_o(endianness_strap_i), .vector_base_strap_o(vector_base_strap_i));
  cbc_core_config #(.PRIO_BITS(4), .PU_REGIONS(16), .FPU_CFG(cbc_pkg::CBC_FPU_SINGLE)) dut (.wb_sel_i(4'hF), .*);
  // one classic cycle: hold until ack or err is sampled, then release
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // reset with chosen straps for eight cycles, then let the boot fetches finish
  task automatic boot(input logic b, input logic [24:0] v);
    be <= b;
    base <= v;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // main sequence: straps, table base, priority fields, fixed registers
  initial begin
    void'($urandom(32'h93F61483));
    for (int i = 0; i < 3; i++) begin
      logic [24:0] v;
      v = (i == 2) ? 25'h1FFFFFF : 25'($urandom);
      boot(i[0], v);
      `CHK(big_endian_o, i[0])
      `CHK(boot_done_o, 1'b1)
      bus(1'b0, `CBC_ADDR_STATUS, 32'h0);
      `CHK(q[0], i[0])
      bus(1'b0, `CBC_ADDR_VTB, 32'h0);
      `CHK(q[31:7], v)
      $display("reset test %0d done", i);
    end
    for (int i = 0; i < 9; i++) begin
      logic [31:0] a, d;
      a = `CBC_ADDR_PRIO_BASE + 32'(4 * (i == 0 ? 0 : i == 1 ? `CBC_PRIO_WORDS - 1 : $urandom_range(59)));
      d = (i == 0) ? 32'hFFFFFFFF : $urandom;
      bus(1'b1, i == 8 ? `CBC_ADDR_VTB : a, d);
      bus(1'b0, i == 8 ? `CBC_ADDR_VTB : a, 32'h0);
      if (i == 8) `CHK(q[31:7], d[31:7])
      else `CHK(q, d & {4{8'hF0}})
    end
    $display("register write test done");
    bus(1'b0, `CBC_ADDR_PU_TYPE, 32'h0);
    `CHK(q[15:8], 8'h10)
    bus(1'b1, `CBC_ADDR_PU_TYPE, $urandom);
    `CHK(e, 1'b1)
    bus(1'b0, 32'h00000100, 32'h0);
    `CHK(e, 1'b1)
    bus(1'b0, `CBC_ADDR_BOOT, 32'h0);
    `CHK(q & 32'h003FC0FF, {10'h0, 1'b1, 2'(cbc_pkg::CBC_FPU_SINGLE), 1'b1, 4'h4, 6'h0, 8'hF0})
    bus(1'b0, `CBC_ADDR_GPR_BASE, 32'h0);
    `CHK(^q === 1'bX, 1'b0)
    $display("fixed register test done");
    summarize();
  end
  // watchdog against a hung handshake
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule // cbc_core_config_test
bind cbc_core_config cbc_core_config_chk #(.PRIO_BITS(PRIO_BITS), .PU_PRESENT(PU_PRESENT),
  .PU_REGIONS(PU_REGIONS)) chk (.*);
